// ===== phy_ctrl_regs.svh
// register map, field positions and counts of the basic control register.
// assumes a single management serial port and one 100 MHz core clock.
`ifndef PHY_CTRL_REGS_SVH
`define PHY_CTRL_REGS_SVH

`define CTL_REG_ADDR 5'h00
`define CTL_RESET 16'h1040
`define BIT_SOFT_RESET_TRIGGER 15
`define BIT_LOOPBACK 14
`define BIT_SPEED_LSB 13
`define BIT_ANEG_EN 12
`define BIT_PWR_DOWN 11
`define BIT_ISOLATE 10
`define BIT_ANEG_RESTART 9
`define BIT_DUPLEX 8
`define BIT_COL_TEST 7
`define BIT_SPEED_MSB 6
`define RO_ZERO_MSB 5
`define SPEED_RESERVED 2'h3
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define HDR_BITS 5'h0c
`define DATA_BITS 5'h10
`define RST_CNT_W 16
`define RESET_CYCLES_DEF 16'h0010

`endif

// ===== phy_ctrl_pkg.sv
// types of the basic control register block.
// assumes phy_ctrl_regs.svh supplies the widths.
`include "phy_ctrl_regs.svh"

package phy_ctrl_pkg;

    typedef enum logic [2:0]
    {
        MD_IDLE = 3'b000,
        MD_START = 3'b001,
        MD_HEAD = 3'b010,
        MD_TURN = 3'b011,
        MD_DATA = 3'b100
    } mdio_state_t;

    typedef struct packed
    {
        logic [15:0] ctl;
        logic [1:0] strap_speed;
        logic strap_aneg;
        logic strap_pd;
        logic mdc_q;
        mdio_state_t fsm;
        logic [4:0] cnt;
        logic [15:0] shreg;
        logic op_read;
        logic hit;
        logic is_ctl;
        logic mdio_out;
        logic mdio_oe;
        logic [`RST_CNT_W-1:0] rst_cnt;
        logic restart_pulse;
        logic tx_en;
    } ctl_state_t;

endpackage

// ===== phy_basic_control_register.sv
// basic control register with its management serial slave.
// assumes mdc and mdio are already synchronous to core_clk_i and that
// the mdc high and low phases each span at least two core clocks.
`timescale 1ns/10ps
`include "phy_ctrl_regs.svh"

module phy_basic_control_register
    import phy_ctrl_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h00,
    parameter logic [`RST_CNT_W-1:0] RESET_CYCLES = `RESET_CYCLES_DEF
)
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    input wire logic [1:0] strap_speed_i,
    input wire logic strap_aneg_i,
    input wire logic strap_pd_i,
    input wire logic link_up_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    output logic soft_reset_trigger_o,
    output logic loopback_o,
    output logic [1:0] speed_o,
    output logic negotiation_enable_o,
    output logic soft_power_down_o,
    output logic isolate_o,
    output logic negotiation_restart_o,
    output logic full_duplex_select_o,
    output logic collision_signal_test_o,
    output logic mac_tx_enable_o
);

    ctl_state_t st;
    ctl_state_t nx;
    logic rise;
    logic commit;
    logic [15:0] wr_word;
    logic [15:0] rd_val;

    function automatic logic [15:0] ctl_default(input logic [1:0] spd,
                                                input logic an,
                                                input logic pd);
        logic [15:0] v;
        v = `CTL_RESET;
        v[`BIT_SPEED_MSB] = spd[1];
        v[`BIT_SPEED_LSB] = spd[0];
        v[`BIT_ANEG_EN] = an;
        v[`BIT_PWR_DOWN] = pd;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        nx = st;
        nx.restart_pulse = 1'b0;
        nx.mdc_q = mdc_i;
        rise = mdc_i & ~st.mdc_q;
        commit = 1'b0;
        wr_word = {st.shreg[14:0], mdio_i};
        rd_val = st.is_ctl ? st.ctl : 16'h0000;

        case (st.fsm)
            MD_IDLE:
            begin
                // any number of preamble ones, including none, is accepted
                if (rise && !mdio_i)
                    nx.fsm = MD_START;
            end
            MD_START:
            begin
                if (rise)
                begin
                    nx.fsm = mdio_i ? MD_HEAD : MD_IDLE;
                    nx.cnt = 5'h00;
                end
            end
            MD_HEAD:
            begin
                if (rise)
                begin
                    nx.shreg = wr_word;
                    nx.cnt = st.cnt + 5'h01;
                    if (st.cnt == `HDR_BITS - 5'h01)
                    begin
                        nx.cnt = 5'h00;
                        nx.op_read = (wr_word[11:10] == `OP_READ);
                        nx.hit = (wr_word[9:5] == PHY_ADDR);
                        nx.is_ctl = (wr_word[4:0] == `CTL_REG_ADDR);
                        if (wr_word[11:10] == `OP_READ ||
                            wr_word[11:10] == `OP_WRITE)
                            nx.fsm = MD_TURN;
                        else
                            nx.fsm = MD_IDLE;
                    end
                end
            end
            MD_TURN:
            begin
                if (rise)
                begin
                    nx.cnt = st.cnt + 5'h01;
                    if (st.op_read && st.hit)
                    begin
                        nx.mdio_oe = 1'b1;
                        nx.mdio_out = 1'b0;
                    end
                    if (st.cnt != 5'h00)
                    begin
                        nx.fsm = MD_DATA;
                        nx.cnt = 5'h00;
                        if (st.op_read && st.hit)
                        begin
                            nx.mdio_out = rd_val[15];
                            nx.shreg = {rd_val[14:0], 1'b0};
                        end
                    end
                end
            end
            MD_DATA:
            begin
                if (rise)
                begin
                    nx.cnt = st.cnt + 5'h01;
                    if (st.op_read)
                    begin
                        nx.mdio_out = st.shreg[15];
                        nx.shreg = {st.shreg[14:0], 1'b0};
                    end
                    else
                        nx.shreg = wr_word;
                    if (st.cnt == `DATA_BITS - 5'h01)
                    begin
                        nx.fsm = MD_IDLE;
                        nx.mdio_oe = 1'b0;
                        nx.mdio_out = 1'b0;
                        // writes are dropped while a soft reset runs
                        commit = !st.op_read && st.hit && st.is_ctl &&
                                 !st.ctl[`BIT_SOFT_RESET_TRIGGER];
                    end
                end
            end
            default:
            begin
                nx.fsm = MD_IDLE;
                nx.mdio_oe = 1'b0;
            end
        endcase

        if (st.ctl[`BIT_SOFT_RESET_TRIGGER])
        begin
            if (st.rst_cnt == RESET_CYCLES - 16'h0001)
            begin
                nx.ctl = ctl_default(st.strap_speed, st.strap_aneg,
                                     st.strap_pd);
                nx.rst_cnt = '0;
            end
            else
                nx.rst_cnt = st.rst_cnt + 16'h0001;
        end

        if (st.ctl[`BIT_ANEG_RESTART])
        begin
            nx.ctl[`BIT_ANEG_RESTART] = 1'b0;
            nx.restart_pulse = 1'b1;
        end

        if (commit)
        begin
            nx.ctl[15:7] = wr_word[15:7];
            nx.ctl[`BIT_SPEED_MSB] = wr_word[`BIT_SPEED_MSB];
            // a reserved speed code is refused; the old speed stays
            if ({wr_word[`BIT_SPEED_MSB], wr_word[`BIT_SPEED_LSB]} ==
                `SPEED_RESERVED)
            begin
                nx.ctl[`BIT_SPEED_MSB] = st.ctl[`BIT_SPEED_MSB];
                nx.ctl[`BIT_SPEED_LSB] = st.ctl[`BIT_SPEED_LSB];
            end
        end
        nx.ctl[`RO_ZERO_MSB:0] = '0;

        // no MAC transmit while isolated, powered down, resetting or no link
        nx.tx_en = link_up_i & ~nx.ctl[`BIT_ISOLATE] &
                   ~nx.ctl[`BIT_PWR_DOWN] & ~nx.ctl[`BIT_SOFT_RESET_TRIGGER];

        if (rst_i)
        begin
            nx = '0;
            nx.fsm = MD_IDLE;
            nx.mdc_q = mdc_i;
            nx.strap_speed = strap_speed_i;
            nx.strap_aneg = strap_aneg_i;
            nx.strap_pd = strap_pd_i;
            nx.ctl = ctl_default(strap_speed_i, strap_aneg_i,
                                 strap_pd_i);
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        st <= nx;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign mdio_o = st.mdio_out;
    assign mdio_oe_o = st.mdio_oe;
    assign soft_reset_trigger_o = st.ctl[`BIT_SOFT_RESET_TRIGGER];
    assign loopback_o = st.ctl[`BIT_LOOPBACK];
    assign speed_o = {st.ctl[`BIT_SPEED_MSB], st.ctl[`BIT_SPEED_LSB]};
    assign negotiation_enable_o = st.ctl[`BIT_ANEG_EN];
    assign soft_power_down_o = st.ctl[`BIT_PWR_DOWN];
    assign isolate_o = st.ctl[`BIT_ISOLATE];
    assign negotiation_restart_o = st.restart_pulse;
    assign full_duplex_select_o = st.ctl[`BIT_DUPLEX];
    assign collision_signal_test_o = st.ctl[`BIT_COL_TEST];
    assign mac_tx_enable_o = st.tx_en;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    chk_sftrst_done: assert property (
        st.ctl[`BIT_SOFT_RESET_TRIGGER] && st.rst_cnt == RESET_CYCLES - 16'h0001
        |=> !soft_reset_trigger_o && st.ctl == ctl_default(st.strap_speed,
            st.strap_aneg, st.strap_pd))
        else $error("soft reset did not finish with defaults");
    chk_sftrst_bound: assert property (
        st.rst_cnt < RESET_CYCLES)
        else $error("soft reset counter overran");
    chk_loopback_wr: assert property (
        commit |=> loopback_o == $past(wr_word[`BIT_LOOPBACK]))
        else $error("loopback did not follow write");
    chk_speed_wr: assert property (
        commit && {wr_word[`BIT_SPEED_MSB], wr_word[`BIT_SPEED_LSB]}
            != `SPEED_RESERVED
        |=> speed_o == $past({wr_word[`BIT_SPEED_MSB],
                              wr_word[`BIT_SPEED_LSB]}))
        else $error("speed did not follow write");
    // only strapped defaults may bring in the reserved speed code
    chk_speed_resv: assert property (
        $changed(speed_o) && speed_o == `SPEED_RESERVED
        |-> $past(soft_reset_trigger_o))
        else $error("reserved speed appeared");
    chk_reset_value: assert property (
        $fell(rst_i) |-> st.ctl == ctl_default($past(strap_speed_i),
            $past(strap_aneg_i), $past(strap_pd_i)))
        else $error("reset value wrong");
    chk_aneg_wr: assert property (
        commit |=> negotiation_enable_o == $past(wr_word[`BIT_ANEG_EN]))
        else $error("autoneg enable did not follow write");
    chk_pd_hold: assert property (
        soft_power_down_o && !commit && !soft_reset_trigger_o
        |=> soft_power_down_o)
        else $error("power-down dropped without software");
    chk_isolate_tx: assert property (
        isolate_o |-> !mac_tx_enable_o)
        else $error("transmit enabled while isolated");
    chk_restart_clr: assert property (
        st.ctl[`BIT_ANEG_RESTART] && !commit
        |=> !st.ctl[`BIT_ANEG_RESTART] && negotiation_restart_o)
        else $error("restart bit did not self-clear");
    chk_collision_signal_test_wr: assert property (
        commit |=> collision_signal_test_o == $past(wr_word[`BIT_COL_TEST]))
        else $error("collision test did not follow write");
    chk_ro_bits: assert property (
        st.ctl[`RO_ZERO_MSB:0] == '0)
        else $error("read-only bits set");
    chk_tx_link: assert property (
        !$past(link_up_i) |-> !mac_tx_enable_o)
        else $error("transmit enabled without link");
    chk_duplex_wr: assert property (
        commit |=> full_duplex_select_o == $past(wr_word[`BIT_DUPLEX]))
        else $error("duplex did not follow write");

endmodule

// ===== mdio_station_model.sv
// management station model: sends serial frames on mdc and mdio.
// assumes the bench resolves the mdio wire from both parties' enables.
`timescale 1ns/10ps
`include "phy_ctrl_regs.svh"
module mdio_station_model
(
    input wire logic core_clk_i,
    input wire logic mdio_line_i,
    output logic mdc_o,
    output logic drive_o,
    output logic drive_en_o
);
    initial
    begin
        mdc_o = 1'b0;
        drive_o = 1'b1;
        drive_en_o = 1'b0;
    end

    // two core cycles low then four high: both phases at least two cycles
    task automatic bit_cyc(input logic b, input logic en, output logic s);
        @(posedge core_clk_i);
        mdc_o <= 1'b0;
        drive_o <= b;
        drive_en_o <= en;
        repeat (2) @(posedge core_clk_i);
        s = mdio_line_i;
        mdc_o <= 1'b1;
        repeat (3) @(posedge core_clk_i);
    endtask

    // read data is sampled late in the low phase, where it has settled
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
        input logic [4:0] ra, input logic [15:0] wd, input int pre,
        output logic [15:0] rd);
        logic [31:0] hdr;
        logic s;
        logic rdop;
        rdop = (op == `OP_READ);
        hdr = {2'b01, op, phy, ra, 2'b10, wd};
        for (int i = 0; i < pre; i++)
            bit_cyc(1'b1, 1'b1, s);
        for (int i = 31; i >= 0; i--)
        begin
            bit_cyc(hdr[i], !(rdop && i < 18), s);
            if (i < 16)
                rd[i] = s;
        end
        // clock stands still and the line is released between frames
        @(posedge core_clk_i);
        mdc_o <= 1'b0;
        drive_en_o <= 1'b0;
    endtask
endmodule

// ===== phy_basic_control_register_tb_top.sv
// self-checking bench of the basic control register.
// assumes the station model drives every frame on the serial port.
`timescale 1ns/10ps
`include "phy_ctrl_regs.svh"
module phy_basic_control_register_tb_top;
    logic core_clk_i, rst_i, mdc, drv, drv_en, flt, link_up, an, pd;
    logic [1:0] ssp, speed;
    logic m_o, m_oe, srst, lb, ane, spd, iso, rs, fd, col, tx;
    logic [15:0] exp_v, r;
    integer seed, n_errors, checks, n_pulse, n_oe, p0, o0;
    wire logic line = m_oe ? m_o : (drv_en ? drv : flt);

    phy_basic_control_register #(.RESET_CYCLES(16'h0190)) DUT (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .mdc_i(mdc),
        .mdio_i(line), .strap_speed_i(ssp), .strap_aneg_i(an),
        .strap_pd_i(pd), .link_up_i(link_up), .mdio_o(m_o),
        .mdio_oe_o(m_oe), .soft_reset_trigger_o(srst), .loopback_o(lb),
        .speed_o(speed), .negotiation_enable_o(ane),
        .soft_power_down_o(spd), .isolate_o(iso),
        .negotiation_restart_o(rs), .full_duplex_select_o(fd),
        .collision_signal_test_o(col), .mac_tx_enable_o(tx));
    mdio_station_model u_sta (.core_clk_i(core_clk_i),
        .mdio_line_i(line), .mdc_o(mdc), .drive_o(drv),
        .drive_en_o(drv_en));

    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
    begin
        flt <= ~flt;
        if (rs === 1'b1) n_pulse <= n_pulse + 1;
        if (m_oe === 1'b1) n_oe <= n_oe + 1;
    end

    ////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] defv(logic [1:0] s, logic a, logic p);
        defv = {2'b00, s[0], a, p, 4'h0, s[1], 6'h00};
    endfunction
    // speed code 11 is refused; self-clearing and read-zero bits drop
    function automatic logic [15:0] wrv(logic [15:0] o, logic [15:0] w);
        wrv = w & 16'h7dc0;
        if ({w[6], w[13]} == `SPEED_RESERVED)
        begin
            wrv[13] = o[13];
            wrv[6] = o[6];
        end
    endfunction
    task automatic chk_w(string nm, logic [15:0] e, logic [15:0] g);
        checks = checks + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_b(string nm, logic e, logic g);
        chk_w(nm, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic wr(logic [4:0] ph, logic [4:0] ra, logic [15:0] d);
        logic [15:0] x;
        u_sta.frame(`OP_WRITE, ph, ra, d, 0, x);
        repeat (3) @(posedge core_clk_i);
    endtask
    task automatic rd(logic [4:0] ph, logic [4:0] ra);
        u_sta.frame(`OP_READ, ph, ra, 16'h0000, 2, r);
    endtask
    task automatic outs();
        @(posedge core_clk_i);
        link_up <= 1'($random(seed));
        repeat (3) @(posedge core_clk_i);
        chk_b("loopback", exp_v[14], lb);
        chk_w("speed", {14'h0000, exp_v[6], exp_v[13]}, {14'h0000, speed});
        chk_b("aneg", exp_v[12], ane);
        chk_b("power_down", exp_v[11], spd);
        chk_b("isolate", exp_v[10], iso);
        chk_b("duplex", exp_v[8], fd);
        chk_b("col_test", exp_v[7], col);
        chk_b("tx_en", link_up & ~exp_v[10] & ~exp_v[11], tx);
    endtask
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        #600000;
        n_errors = n_errors + 1;
        tally_and_finish();
    end
    initial
    begin
        seed = 32'h8e1aef6d;
        {n_errors, checks, n_pulse, n_oe} = '0;
        {rst_i, flt, link_up, ssp, an, pd} = 7'b1001010;
        for (int k = 0; k < 3; k++)
        begin
            @(posedge core_clk_i);
            if (k > 0) {ssp, an, pd} <= 4'($random(seed));
            rst_i <= 1'b1;
            repeat (6) @(posedge core_clk_i);
            rst_i <= 1'b0;
            exp_v = defv(ssp, an, pd);
            rd(5'h00, `CTL_REG_ADDR);
            chk_w("reset_value", exp_v, r);
            outs();
        end
        for (int i = 0; i < 10; i++)
        begin
            r = (i == 0) ? 16'h7fff : 16'($random(seed));
            r[15] = 1'b0;
            p0 = n_pulse;
            wr(5'h00, `CTL_REG_ADDR, r);
            chk_w("restart_pulses", {15'h0000, r[9]}, 16'(n_pulse - p0));
            exp_v = wrv(exp_v, r);
            rd(5'h00, `CTL_REG_ADDR);
            chk_w("readback", exp_v, r);
            outs();
        end
        rd(5'h00, 5'h01);
        chk_w("other_reg", 16'h0000, r);
        wr(5'h00, 5'h01, ~exp_v);
        o0 = n_oe;
        wr(5'h01, `CTL_REG_ADDR, ~exp_v);
        rd(5'h01, `CTL_REG_ADDR);
        chk_w("foreign_drive", 16'(o0), 16'(n_oe));
        rd(5'h00, `CTL_REG_ADDR);
        chk_w("kept", exp_v, r);
        wr(5'h00, `CTL_REG_ADDR, 16'hc500);
        chk_b("soft_reset", 1'b1, srst);
        wr(5'h00, `CTL_REG_ADDR, 16'h0100);
        for (int t = 0; t < 1000 && srst !== 1'b0; t++)
            @(posedge core_clk_i);
        chk_b("soft_reset_done", 1'b0, srst);
        exp_v = defv(ssp, an, pd);
        rd(5'h00, `CTL_REG_ADDR);
        chk_w("after_soft_reset", exp_v, r);
        outs();
        tally_and_finish();
    end
endmodule
